// >>> src/bsti_pkg.sv
`default_nettype none

package bsti_pkg;

    localparam int unsigned IR_W        = 3;
    localparam int unsigned ID_W        = 32;
    localparam logic [2:0]  IR_CAPTURE  = 3'h1;
    localparam logic [2:0]  INS_EXTEST  = 3'h0;
    localparam logic [2:0]  INS_IDCODE  = 3'h1;
    localparam logic [2:0]  INS_SAMPLEZ = 3'h2;
    localparam logic [2:0]  INS_PRIV_A  = 3'h3;
    localparam logic [2:0]  INS_SAMPLE  = 3'h4;
    localparam logic [2:0]  INS_PRIV_B  = 3'h5;
    localparam logic [2:0]  INS_PRIV_C  = 3'h6;
    localparam logic [2:0]  INS_BYPASS  = 3'h7;
    localparam logic        BSR_DEFAULT = 1'h1;
    localparam logic        BYPASS_CAP  = 1'h0;

    typedef enum logic [3:0] {
        TLR, RTI,
        SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } bsti_state_t;

    typedef struct packed {
        logic bsr;
        logic idreg;
        logic bypass;
        logic extest;
        logic highz;
    } bsti_sel_t;

    function automatic bsti_sel_t bsti_decode(input logic [2:0] ins);
        bsti_sel_t s;
        s = '0;
        case (ins)
            INS_EXTEST:  begin s.bsr = 1'b1; s.extest = 1'b1; end
            INS_IDCODE:  s.idreg = 1'b1;
            INS_SAMPLEZ: begin s.bsr = 1'b1; s.highz = 1'b1; end
            INS_SAMPLE:  s.bsr = 1'b1;
            // Reserved codes fall back to the one-bit path so the chain length stays defined
            default:     s.bypass = 1'b1;
        endcase
        return s;
    endfunction : bsti_decode

endpackage : bsti_pkg

`default_nettype wire

// >>> src/bsti_tap_fsm.sv
`default_nettype none

module bsti_tap_fsm (
    input  wire logic           tck_i,
    input  wire logic           rst_i,
    input  wire logic           tms_i,
    output bsti_pkg::bsti_state_t state_o
);

    bsti_pkg::bsti_state_t state_q;
    bsti_pkg::bsti_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            bsti_pkg::TLR:      state_d = tms_i ? bsti_pkg::TLR      : bsti_pkg::RTI;
            bsti_pkg::RTI:      state_d = tms_i ? bsti_pkg::SEL_DR   : bsti_pkg::RTI;
            bsti_pkg::SEL_DR:   state_d = tms_i ? bsti_pkg::SEL_IR   : bsti_pkg::CAP_DR;
            bsti_pkg::CAP_DR:   state_d = tms_i ? bsti_pkg::EXIT1_DR : bsti_pkg::SHIFT_DR;
            bsti_pkg::SHIFT_DR: state_d = tms_i ? bsti_pkg::EXIT1_DR : bsti_pkg::SHIFT_DR;
            bsti_pkg::EXIT1_DR: state_d = tms_i ? bsti_pkg::UPD_DR   : bsti_pkg::PAUSE_DR;
            bsti_pkg::PAUSE_DR: state_d = tms_i ? bsti_pkg::EXIT2_DR : bsti_pkg::PAUSE_DR;
            bsti_pkg::EXIT2_DR: state_d = tms_i ? bsti_pkg::UPD_DR   : bsti_pkg::SHIFT_DR;
            bsti_pkg::UPD_DR:   state_d = tms_i ? bsti_pkg::SEL_DR   : bsti_pkg::RTI;
            bsti_pkg::SEL_IR:   state_d = tms_i ? bsti_pkg::TLR      : bsti_pkg::CAP_IR;
            bsti_pkg::CAP_IR:   state_d = tms_i ? bsti_pkg::EXIT1_IR : bsti_pkg::SHIFT_IR;
            bsti_pkg::SHIFT_IR: state_d = tms_i ? bsti_pkg::EXIT1_IR : bsti_pkg::SHIFT_IR;
            bsti_pkg::EXIT1_IR: state_d = tms_i ? bsti_pkg::UPD_IR   : bsti_pkg::PAUSE_IR;
            bsti_pkg::PAUSE_IR: state_d = tms_i ? bsti_pkg::EXIT2_IR : bsti_pkg::PAUSE_IR;
            bsti_pkg::EXIT2_IR: state_d = tms_i ? bsti_pkg::UPD_IR   : bsti_pkg::SHIFT_IR;
            bsti_pkg::UPD_IR:   state_d = tms_i ? bsti_pkg::SEL_DR   : bsti_pkg::RTI;
            default:            state_d = bsti_pkg::TLR;
        endcase
    end

    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= bsti_pkg::TLR;
        end else begin
            state_q <= state_d;
        end
    end

    assign state_o = state_q;

endmodule : bsti_tap_fsm

`default_nettype wire

// >>> src/bsti_top.sv
`default_nettype none

module bsti_top #(
    parameter int unsigned N_IN    = 8,
    parameter int unsigned N_OUT   = 8,
    parameter int unsigned N_FIX   = 2,
    // Arbitrary identification value
    parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             tck_i,
    input  wire logic             tms_i,
    input  wire logic             tdi_i,
    output logic                  tdo_o,
    output logic                  tdo_oe_o,
    input  wire logic [N_IN-1:0]  pad_in_i,
    input  wire logic [N_OUT-1:0] func_out_i,
    input  wire logic [N_OUT-1:0] func_oe_i,
    output logic      [N_OUT-1:0] pad_out_o,
    output logic      [N_OUT-1:0] pad_oe_o,
    output logic                  memory_clock_input_en_o
);

    localparam int unsigned BSR_LEN = N_IN + N_OUT + N_FIX;

    // TCK-domain reset; release synchronised so the TAP never leaves TLR on a runt edge
    logic tap_rst_meta_q;
    logic tap_rst_q;

    always_ff @(posedge tck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tap_rst_meta_q <= 1'b1;
            tap_rst_q      <= 1'b1;
        end else begin
            tap_rst_meta_q <= 1'b0;
            tap_rst_q      <= tap_rst_meta_q;
        end
    end

    bsti_pkg::bsti_state_t fsm_q;

    bsti_tap_fsm u_fsm (
        .tck_i   (tck_i),
        .rst_i   (tap_rst_q),
        .tms_i   (tms_i),
        .state_o (fsm_q)
    );

    // Pad levels come from the memory clock domain; capture is only repeatable
    // when the system holds them still around Capture-DR
    logic [N_IN-1:0] pad_s1_q;
    logic [N_IN-1:0] pad_s2_q;

    always_ff @(posedge tck_i or posedge tap_rst_q) begin
        if (tap_rst_q) begin
            pad_s1_q <= '0;
            pad_s2_q <= '0;
        end else begin
            pad_s1_q <= pad_in_i;
            pad_s2_q <= pad_s1_q;
        end
    end

    // Rising-edge shift and capture group
    logic [bsti_pkg::IR_W-1:0] ir_shift_q, ir_shift_d;
    logic                      bypass_q, bypass_d;
    logic [bsti_pkg::ID_W-1:0] id_q, id_d;
    logic [BSR_LEN-1:0]        bsr_q, bsr_d;
    logic [N_OUT-1:0]          upd_q, upd_d;
    logic                      upd_tgl_q, upd_tgl_d;
    logic [BSR_LEN-1:0]        cap_vec;
    logic [bsti_pkg::IR_W-1:0] ir_active_q, ir_active_d;
    bsti_pkg::bsti_sel_t       sel;

    assign sel     = bsti_pkg::bsti_decode(ir_active_q);
    assign cap_vec = {{(N_OUT + N_FIX){bsti_pkg::BSR_DEFAULT}}, pad_s2_q};

    always_comb begin
        ir_shift_d = ir_shift_q;
        bypass_d   = bypass_q;
        id_d       = id_q;
        bsr_d      = bsr_q;
        upd_d      = upd_q;
        upd_tgl_d  = upd_tgl_q;
        case (fsm_q)
            bsti_pkg::CAP_IR:   ir_shift_d = bsti_pkg::IR_CAPTURE;
            bsti_pkg::SHIFT_IR: ir_shift_d = {tdi_i, ir_shift_q[bsti_pkg::IR_W-1:1]};
            bsti_pkg::CAP_DR: begin
                if (sel.bsr) begin
                    bsr_d = cap_vec;
                end else if (sel.idreg) begin
                    id_d = ID_CODE;
                end else begin
                    bypass_d = bsti_pkg::BYPASS_CAP;
                end
            end
            bsti_pkg::SHIFT_DR: begin
                if (sel.bsr) begin
                    bsr_d = {tdi_i, bsr_q[BSR_LEN-1:1]};
                end else if (sel.idreg) begin
                    id_d = {tdi_i, id_q[bsti_pkg::ID_W-1:1]};
                end else begin
                    bypass_d = tdi_i;
                end
            end
            bsti_pkg::UPD_DR: begin
                if (sel.bsr) begin
                    upd_d     = bsr_q[N_IN +: N_OUT];
                    upd_tgl_d = ~upd_tgl_q;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge tck_i or posedge tap_rst_q) begin
        if (tap_rst_q) begin
            ir_shift_q <= bsti_pkg::INS_IDCODE;
            bypass_q   <= 1'b0;
            id_q       <= '0;
            bsr_q      <= '0;
            upd_q      <= '0;
            upd_tgl_q  <= 1'b0;
        end else begin
            ir_shift_q <= ir_shift_d;
            bypass_q   <= bypass_d;
            id_q       <= id_d;
            bsr_q      <= bsr_d;
            upd_q      <= upd_d;
            upd_tgl_q  <= upd_tgl_d;
        end
    end

    // Falling-edge group: active instruction and TDO
    logic tdo_q, tdo_d;
    logic tdo_oe_q, tdo_oe_d;

    always_comb begin
        ir_active_d = ir_active_q;
        tdo_d       = tdo_q;
        tdo_oe_d    = 1'b0;
        if (fsm_q == bsti_pkg::TLR) begin
            ir_active_d = bsti_pkg::INS_IDCODE;
        end else if (fsm_q == bsti_pkg::UPD_IR) begin
            ir_active_d = ir_shift_q;
        end
        if (fsm_q == bsti_pkg::SHIFT_IR) begin
            tdo_d    = ir_shift_q[0];
            tdo_oe_d = 1'b1;
        end else if (fsm_q == bsti_pkg::SHIFT_DR) begin
            tdo_oe_d = 1'b1;
            if (sel.bsr) begin
                tdo_d = bsr_q[0];
            end else if (sel.idreg) begin
                tdo_d = id_q[0];
            end else begin
                tdo_d = bypass_q;
            end
        end
    end

    always_ff @(negedge tck_i or posedge tap_rst_q) begin
        if (tap_rst_q) begin
            ir_active_q <= bsti_pkg::INS_IDCODE;
            tdo_q       <= 1'b0;
            tdo_oe_q    <= 1'b0;
        end else begin
            ir_active_q <= ir_active_d;
            tdo_q       <= tdo_d;
            tdo_oe_q    <= tdo_oe_d;
        end
    end

    assign tdo_o    = tdo_q;
    assign tdo_oe_o = tdo_oe_q;

    // Memory clock domain: levels by two flops, update word by toggle.
    // upd_q is only rewritten in Update-DR, many TCK edges apart, so it is stable when sampled.
    logic             ext_s1_q, ext_s2_q;
    logic             hiz_s1_q, hiz_s2_q;
    logic             tgl_s1_q, tgl_s2_q, tgl_s3_q;
    logic [N_OUT-1:0] hold_q, hold_d;
    logic [N_OUT-1:0] pad_out_q, pad_out_d;
    logic [N_OUT-1:0] pad_oe_q, pad_oe_d;
    logic             clk_en_q, clk_en_d;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            hiz_s1_q <= 1'b0;
            hiz_s2_q <= 1'b0;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= sel.extest;
            ext_s2_q <= ext_s1_q;
            hiz_s1_q <= sel.highz;
            hiz_s2_q <= hiz_s1_q;
            tgl_s1_q <= upd_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    always_comb begin
        hold_d = hold_q;
        if (tgl_s2_q != tgl_s3_q) begin
            hold_d = upd_q;
        end
        pad_out_d = ext_s2_q ? hold_q : func_out_i;
        if (hiz_s2_q) begin
            pad_oe_d = '0;
        end else if (ext_s2_q) begin
            pad_oe_d = '1;
        end else begin
            pad_oe_d = func_oe_i;
        end
        clk_en_d = ~ext_s2_q;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_q    <= '0;
            pad_out_q <= '0;
            pad_oe_q  <= '0;
            clk_en_q  <= 1'b1;
        end else begin
            hold_q    <= hold_d;
            pad_out_q <= pad_out_d;
            pad_oe_q  <= pad_oe_d;
            clk_en_q  <= clk_en_d;
        end
    end

    assign pad_out_o               = pad_out_q;
    assign pad_oe_o                = pad_oe_q;
    assign memory_clock_input_en_o = clk_en_q;

    // Checks, TCK domain
    chk_ir_capture: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::CAP_IR |=> ir_shift_q[1:0] == 2'h1)
        else $error("capture-ir did not load 01");

    chk_ir_shift: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::SHIFT_IR |=> ir_shift_q == {$past(tdi_i), $past(ir_shift_q[2:1])})
        else $error("instruction shift path wrong");

    chk_ir_hold: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        !(fsm_q inside {bsti_pkg::UPD_IR, bsti_pkg::TLR}) |-> $stable(ir_active_q))
        else $error("active instruction changed outside update-ir");

    chk_ir_reset: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::TLR |-> ir_active_q == bsti_pkg::INS_IDCODE)
        else $error("reset state lost id instruction");

    chk_bypass_path: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::SHIFT_DR && sel.bypass |=> bypass_q == $past(tdi_i))
        else $error("bypass bit not loaded from tdi");

    chk_bsr_capture: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::CAP_DR && sel.bsr |=> bsr_q == $past(cap_vec)
        && bsr_q[BSR_LEN-1:N_IN] == '1)
        else $error("boundary capture wrong");

    chk_upd_load: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::UPD_DR && sel.bsr |=> upd_q == $past(bsr_q[N_IN +: N_OUT]) && upd_tgl_q != $past(upd_tgl_q))
        else $error("update-dr did not load holding register");

    chk_id_capture: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::CAP_DR && ir_active_q == bsti_pkg::INS_IDCODE |=> id_q == ID_CODE)
        else $error("id value not captured");

    chk_tdo_enable: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        ##1 tdo_oe_q == (fsm_q inside {bsti_pkg::SHIFT_IR, bsti_pkg::SHIFT_DR}))
        else $error("tdo enable outside shift states");

    chk_tms_reset: assert property (@(posedge tck_i) disable iff (tap_rst_q)
        tms_i [*5] |=> fsm_q == bsti_pkg::TLR)
        else $error("five tms ones did not reach reset");

    // Checks, memory clock domain
    chk_hiz_outputs: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        hiz_s2_q |=> pad_oe_o == '0)
        else $error("sample-z left an output enabled");

    chk_extest_drive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ext_s2_q && !hiz_s2_q |=> pad_oe_o == '1 && pad_out_o == $past(hold_q) && !memory_clock_input_en_o)
        else $error("external test not driving holding values");

    cov_extest_update: cover property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::UPD_DR && sel.extest);
    cov_id_shift: cover property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::SHIFT_DR && sel.idreg);
    cov_bypass_shift: cover property (@(posedge tck_i) disable iff (tap_rst_q)
        fsm_q == bsti_pkg::SHIFT_DR && sel.bypass);
    cov_highz: cover property (@(posedge mclk_i) disable iff (sys_rst_i) hiz_s2_q);

endmodule : bsti_top

`default_nettype wire

// >>> testbench/bsti_jtag_ctl.sv
`default_nettype none

module bsti_jtag_ctl (
    output logic        tck_o,
    output logic        tms_o,
    output logic        tdi_o,
    input  wire logic   tdo_i,
    input  wire logic   tdo_oe_i,
    output logic [63:0] res_o,
    output logic        res_tgl_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock stands still low between frames; pulled-up pins idle high
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
        res_o = 64'h0;
        res_tgl_o = 1'h0;
    end

    // TDO is read just before the rising edge, well after the falling update
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
        tms_o = tms;
        tdi_o = tdi;
        #6;
        // A released TDO shows the inverse so a read outside shift cannot pass by luck
        tdo = tdo_oe_i ? tdo_i : ~tdo_i;
        oe = tdo_oe_i;
        tck_o = 1'h1;
        #6;
        tck_o = 1'h0;
    endtask : step

    task automatic tap_reset();
        logic d;
        logic e;
        repeat (5) step(1'h1, 1'h1, d, e);
        step(1'h0, 1'h1, d, e);
    endtask : tap_reset

    // From idle: one IR or DR frame, LSB first, then back to idle and a pause
    task automatic scan(input logic ir, input int len, input logic [62:0] din, input int gap);
        logic        d;
        logic        e;
        logic        oe_all;
        logic [63:0] r;
        r = 64'h0;
        oe_all = 1'h1;
        step(1'h1, 1'h1, d, e);
        if (ir) step(1'h1, 1'h1, d, e);
        step(1'h0, 1'h1, d, e);
        step(len == 0, 1'h1, d, e);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1, din[i], d, e);
            r[i] = d;
            oe_all &= e;
        end
        step(1'h1, 1'h1, d, e);
        step(1'h0, 1'h1, d, e);
        step(1'h0, 1'h1, d, e);
        r[63] = oe_all;
        r[62] = ~e;
        tms_o = 1'h1;
        tdi_o = 1'h1;
        res_o = r;
        res_tgl_o = ~res_tgl_o;
        #(gap);
    endtask : scan
endmodule : bsti_jtag_ctl

`default_nettype wire

// >>> testbench/bsti_top_tb_top.sv
`default_nettype none

module bsti_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] ID_VAL  = 32'hA5C3_1E69; // Arbitrary value
    localparam int          BSR_LEN = 18;

    logic        mclk, sys_rst, tck, tms, tdi, tdo, tdo_oe, clk_en, ctl_tgl, pad_tgl;
    logic [7:0]  pad_in, func_out, func_oe, pad_out, pad_oe;
    logic [63:0] ctl_res, pad_obs, exp_q[$];
    logic [62:0] hold;
    // Reserved codes are never loaded by the controller
    logic [2:0]  codes[4] = '{3'h7, 3'h7, 3'h7, 3'h7};
    int          fail_count, n_compared, seed, cycles;

    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    bsti_top #(.ID_CODE(ID_VAL)) dut (
        .mclk_i(mclk), .sys_rst_i(sys_rst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_in_i(pad_in), .func_out_i(func_out),
        .func_oe_i(func_oe), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .memory_clock_input_en_o(clk_en)
    );

    bsti_jtag_ctl ctl (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe),
        .res_o(ctl_res), .res_tgl_o(ctl_tgl)
    );

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic pop_check(input logic [63:0] seen);
        check(seen, (exp_q.size() > 0) ? exp_q.pop_front() : ~seen);
    endtask : pop_check

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    function automatic int gap();
        return 12 * int'($random(seed) & 32'h7);
    endfunction : gap

    // Top two result bits: TDO enabled through the shift, released in idle
    task automatic dr(input int len, input logic [62:0] din, input logic [61:0] exp);
        exp_q.push_back({2'h3, exp});
        ctl.scan(1'h0, len, din, gap());
    endtask : dr

    task automatic ir(input logic [2:0] code);
        exp_q.push_back({2'h3, 62'(bsti_pkg::IR_CAPTURE)});
        ctl.scan(1'h1, 3, 63'(code), gap());
    endtask : ir

    task automatic stim();
        @(negedge mclk);
        pad_in = 8'($random(seed));
        func_out = 8'($random(seed));
        func_oe = 8'($random(seed));
    endtask : stim

    // Memory side lags the link by a few synchroniser stages, so let it settle
    task automatic pads(input logic [16:0] exp);
        repeat (10) @(negedge mclk);
        exp_q.push_back(64'(exp));
        pad_obs = {47'h0, clk_en, pad_oe, pad_out};
        pad_tgl = ~pad_tgl;
    endtask : pads

    initial begin
        #1;
        forever @(ctl_tgl) pop_check(ctl_res);
    end

    initial begin
        #1;
        forever @(pad_tgl) pop_check(pad_obs);
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        seed = 62437;
        fail_count = 0;
        n_compared = 0;
        cycles = 0;
        pad_tgl = 1'h0;
        sys_rst = 1'h1;
        pad_in = 8'h00;
        func_out = 8'h00;
        func_oe = 8'h00;
        repeat (20) @(negedge mclk);
        sys_rst = 1'h0;
        repeat (2) @(negedge mclk);
        ctl.tap_reset();
        dr(32, 63'($random(seed)), 62'(ID_VAL));
        $display("Test power-up ID done");
        foreach (codes[i]) begin
            ir(codes[i]);
            dr(2, 63'h3, 62'({1'h1, bsti_pkg::BYPASS_CAP}));
        end
        $display("Test bypass done");
        ir(bsti_pkg::INS_SAMPLE);
        stim();
        hold = 63'($random(seed) & 32'h3FFFF);
        dr(BSR_LEN, hold, 62'({2'h3, 8'hFF, pad_in}));
        pads({1'h1, func_oe, func_out});
        $display("Test sample/preload done");
        ir(bsti_pkg::INS_EXTEST);
        pads({1'h0, 8'hFF, hold[15:8]});
        dr(0, 63'h0, 62'h0);
        pads({1'h0, 8'hFF, 8'hFF});
        stim();
        hold = 63'($random(seed) & 32'h3FFFF);
        dr(BSR_LEN, hold, 62'({2'h3, 8'hFF, pad_in}));
        pads({1'h0, 8'hFF, hold[15:8]});
        $display("Test external test done");
        ir(bsti_pkg::INS_SAMPLEZ);
        stim();
        pads({1'h1, 8'h00, func_out});
        dr(BSR_LEN, 63'h0, 62'({2'h3, 8'hFF, pad_in}));
        $display("Test high-Z sample done");
        ctl.tap_reset();
        dr(32, 63'h0, 62'(ID_VAL));
        pads({1'h1, func_oe, func_out});
        $display("Test controller reset done");
        repeat (4) @(negedge mclk);
        end_of_test();
    end
endmodule : bsti_top_tb_top

`default_nettype wire
